// ==== src/vpr_regfile.sv ====
`timescale 1ns/1ns
// How it works
// [RULE1] element k of size N occupies bits k*N upward, lowest element lowest
// [RULE2] merging writes leave inactive destination elements untouched
// [RULE3] zeroing writes clear inactive destination elements
// [RULE4] predicate element is one eighth of vector element size
// [RULE5] only the lowest bit of a predicate element decides activity
// [RULE6] sixteen predicate registers, 16 to 256 bits in steps of 16
// [RULE7] thirty-two vector registers, 128 to 2048 bits in steps of 128
// [RULE8] vector length limited by the three level length controls
// [RULE9] predicate and first-fault length are one eighth of vector length
// [RULE10] element sizes 8 to 128 bits, one size per operation
// [RULE11] destructive writes go to a source register, constructive to own index
// [RULE12] masking only applies when a governing predicate is named
// [RULE13] the operation right after a move prefix is paired with it
// [RULE14] index from gp 0-30 or zero, base from gp 0-30 or stack pointer
// [RULE15] gather fills elements from per-element vector addresses
// [RULE16] scatter stores elements to per-element vector addresses
module vpr_regfile #(
   parameter int VLM = vpr_pkg::VL_MAX
) (
   // clock and reset
   input  wire logic                            sys_clk_in,
   input  wire logic                            nrst_in,
   // length control
   input  wire logic [1:0]                      cur_level_in,
   input  wire logic [vpr_pkg::LEN_W-1:0]       vlen_ctrl_level1_in,
   input  wire logic [vpr_pkg::LEN_W-1:0]       vlen_ctrl_level2_in,
   input  wire logic [vpr_pkg::LEN_W-1:0]       vlen_ctrl_level3_in,
   // read ports
   input  wire logic [4:0]                      rd_a_idx_in,
   input  wire logic [4:0]                      rd_b_idx_in,
   input  wire logic [3:0]                      rd_p_idx_in,
   // vector write port
   input  wire logic                            wr_valid_in,
   input  wire logic                            wr_destr_in,
   input  wire logic [4:0]                      wr_dst_in,
   input  wire logic [4:0]                      wr_src_in,
   input  wire logic [2:0]                      wr_esize_in,
   input  wire logic                            wr_pred_in,
   input  wire logic [3:0]                      wr_gp_idx_in,
   input  wire logic                            wr_zero_in,
   input  wire logic [VLM-1:0]                  wr_data_in,
   // predicate and first-fault write
   input  wire logic                            pw_valid_in,
   input  wire logic [3:0]                      pw_idx_in,
   input  wire logic [VLM/8-1:0]                pw_data_in,
   input  wire logic                            ff_we_in,
   input  wire logic [VLM/8-1:0]                ff_data_in,
   // operation issue for prefix pairing
   input  wire logic                            op_valid_in,
   input  wire logic                            op_prefix_in,
   // gather and scatter request
   input  wire logic                            gs_start_in,
   input  wire logic                            gs_store_in,
   input  wire logic                            gs_sv_in,
   input  wire logic [4:0]                      gs_vec_in,
   input  wire logic [4:0]                      gs_dat_in,
   input  wire logic [3:0]                      gs_gp_in,
   input  wire logic [63:0]                     gs_imm_in,
   input  wire logic [4:0]                      scal_sel_in,
   input  wire logic                            scal_base_in,
   input  wire logic [63:0]                     gpr_val_in,
   input  wire logic [63:0]                     sp_val_in,
   // memory side
   input  wire logic                            mem_ack_in,
   input  wire logic [63:0]                     mem_rdata_in,
   // read data
   output logic [VLM-1:0]                       rd_a_out,
   output logic [VLM-1:0]                       rd_b_out,
   output logic [VLM/8-1:0]                     rd_p_out,
   output logic [VLM/8-1:0]                     ff_out,
   // status
   output logic [4:0]                           vl_quads_out,
   output logic                                 paired_out,
   output logic                                 gs_busy_out,
   // memory requests
   output logic                                 mem_req_out,
   output logic                                 mem_we_out,
   output logic [63:0]                          mem_addr_out,
   output logic [63:0]                          mem_wdata_out
);
   localparam int NL = VLM / 8;
   localparam int LW = $clog2(NL);
   localparam int MQ = VLM / vpr_pkg::VL_QUANT;

   // ****************************************
   // elaboration checks
   // ****************************************
   if (VLM % vpr_pkg::VL_QUANT != 0 || VLM < vpr_pkg::VL_MIN ||
       VLM > vpr_pkg::VL_MAX) begin : g_bad_vlm
      $error("vector length parameter out of range");  // RULE7
   end
   if ((VLM/8) % vpr_pkg::PL_QUANT != 0 || VLM/8 > vpr_pkg::PL_MAX) begin : g_bad_plm
      $error("predicate length out of range");  // RULE6
   end

   // ****************************************
   // storage and state
   // ****************************************
   logic [VLM-1:0]            vector_regs_r [vpr_pkg::NUM_VREG];
   logic [NL-1:0]             pred_regs_r [vpr_pkg::NUM_PREG];
   logic [NL-1:0]             first_fault_r;
   logic [4:0]                vlq_r;
   logic [4:0]                vlq_nxt;
   logic [NL-1:0]             in_vl;
   logic [VLM-1:0]            vmask;
   logic [VLM-1:0]            wr_nxt;
   logic [NL-1:0]             gp_bits;
   logic [4:0]                wr_tgt;
   logic                      pend_r;
   vpr_pkg::vpr_gs_state_t    gs_st_r;
   logic [5:0]                gs_el_r;
   logic [5:0]                gs_n_r;
   logic                      gs_store_r;
   logic                      gs_sv_r;
   logic [4:0]                gs_vec_r;
   logic [4:0]                gs_dat_r;
   logic [3:0]                gs_gp_r;
   logic [63:0]               gs_imm_r;
   logic [63:0]               gs_scal_r;
   logic [63:0]               gs_scal_nxt;
   logic [63:0]               gs_elem;
   logic [63:0]               gs_wdat;
   logic                      gs_act;

   // ****************************************
   // vector length
   // ****************************************
   // a level is limited by its own control and all higher ones
   function automatic logic [4:0] vl_min(input logic [4:0] a, input logic [4:0] b);
      vl_min = (a < b) ? a : b;
   endfunction

   always_comb begin
      logic [4:0] q1;
      logic [4:0] q2;
      logic [4:0] q3;
      q1 = 5'(vlen_ctrl_level1_in) + 5'h01;
      q2 = 5'(vlen_ctrl_level2_in) + 5'h01;
      q3 = 5'(vlen_ctrl_level3_in) + 5'h01;
      case (cur_level_in)  // RULE8
         2'h3:    vlq_nxt = q3;
         2'h2:    vlq_nxt = vl_min(q2, q3);
         default: vlq_nxt = vl_min(q1, vl_min(q2, q3));
      endcase
      vlq_nxt = vl_min(vlq_nxt, 5'(MQ));  // RULE7
   end

   // length register, one value shared by all vector registers
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         vlq_r <= 5'h01;
      end else begin
         vlq_r <= vlq_nxt;  // RULE8
      end
   end

   // ****************************************
   // per byte lane masks and merge
   // ****************************************
   assign gp_bits = pred_regs_r[wr_gp_idx_in];
   assign wr_tgt  = wr_destr_in ? wr_src_in : wr_dst_in;  // RULE11

   for (genvar b = 0; b < NL; b++) begin : g_lane
      logic [LW-1:0] first;
      logic          act;
      // one predicate bit per byte, so lane index is also bit index
      assign in_vl[b] = (LW+1)'(b) < (LW+1)'({vlq_r, 4'h0});  // RULE9
      assign vmask[b*8 +: 8] = {8{in_vl[b]}};
      // lowest lane of the element that holds this byte
      assign first = LW'(b) & ~((LW'(1) << wr_esize_in) - LW'(1));  // RULE1 RULE4 RULE10
      assign act = !wr_pred_in || gp_bits[first];  // RULE5 RULE12
      always_comb begin
         if (!in_vl[b]) begin
            wr_nxt[b*8 +: 8] = 8'h00;
         end else if (act) begin
            wr_nxt[b*8 +: 8] = wr_data_in[b*8 +: 8];
         end else if (wr_zero_in) begin
            wr_nxt[b*8 +: 8] = 8'h00;  // RULE3
         end else begin
            wr_nxt[b*8 +: 8] = vector_regs_r[wr_tgt][b*8 +: 8];  // RULE2
         end
      end
   end

   // ****************************************
   // vector registers
   // ****************************************
   // gather results land after a core write, so they win a collision
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < vpr_pkg::NUM_VREG; i++) begin
            vector_regs_r[i] <= '0;
         end
      end else begin
         if (wr_valid_in) begin
            vector_regs_r[wr_tgt] <= wr_nxt;  // RULE11
         end
         if (gs_st_r == vpr_pkg::VPR_GS_SCAN && !gs_store_r && !gs_act &&
             gs_el_r != gs_n_r) begin
            vector_regs_r[gs_dat_r][gs_el_r*64 +: 64] <= 64'h0000_0000_0000_0000;
         end
         if (gs_st_r == vpr_pkg::VPR_GS_WAIT && mem_ack_in && !gs_store_r) begin
            vector_regs_r[gs_dat_r][gs_el_r*64 +: 64] <= mem_rdata_in;  // RULE15
         end
      end
   end

   // predicate and first-fault registers, cut to the current length
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < vpr_pkg::NUM_PREG; i++) begin
            pred_regs_r[i] <= '0;
         end
         first_fault_r <= '0;
      end else begin
         if (pw_valid_in) begin
            pred_regs_r[pw_idx_in] <= pw_data_in & in_vl;  // RULE6 RULE9
         end
         if (ff_we_in) begin
            first_fault_r <= ff_data_in & in_vl;  // RULE9
         end
      end
   end

   // registered read ports, bits past the length read as zero
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_a_out     <= '0;
         rd_b_out     <= '0;
         rd_p_out     <= '0;
         ff_out       <= '0;
         vl_quads_out <= 5'h01;
      end else begin
         rd_a_out     <= vector_regs_r[rd_a_idx_in] & vmask;
         rd_b_out     <= vector_regs_r[rd_b_idx_in] & vmask;
         rd_p_out     <= pred_regs_r[rd_p_idx_in] & in_vl;  // RULE9
         ff_out       <= first_fault_r & in_vl;
         vl_quads_out <= vlq_nxt;
      end
   end

   // ****************************************
   // move prefix pairing
   // ****************************************
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pend_r     <= 1'b0;
         paired_out <= 1'b0;
      end else begin
         paired_out <= op_valid_in && !op_prefix_in && pend_r;  // RULE13
         if (op_valid_in) begin
            pend_r <= op_prefix_in;
         end
      end
   end

   // ****************************************
   // gather and scatter sequencer
   // ****************************************
   // selector 31 is the stack pointer for a base, zero for an index
   always_comb begin
      gs_scal_nxt = gpr_val_in;
      if (scal_sel_in == vpr_pkg::SCAL_SEL_31) begin
         gs_scal_nxt = scal_base_in ? sp_val_in : 64'h0000_0000_0000_0000;  // RULE14
      end
   end

   assign gs_elem = vector_regs_r[gs_vec_r][gs_el_r*64 +: 64];
   assign gs_wdat = vector_regs_r[gs_dat_r][gs_el_r*64 +: 64];
   assign gs_act  = pred_regs_r[gs_gp_r][gs_el_r*8];  // RULE5

   // elements are walked in order; inactive ones make no request
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gs_st_r       <= vpr_pkg::VPR_GS_IDLE;
         gs_el_r       <= 6'h00;
         gs_n_r        <= 6'h00;
         gs_store_r    <= 1'b0;
         gs_sv_r       <= 1'b0;
         gs_vec_r      <= 5'h00;
         gs_dat_r      <= 5'h00;
         gs_gp_r       <= 4'h0;
         gs_imm_r      <= 64'h0000_0000_0000_0000;
         gs_scal_r     <= 64'h0000_0000_0000_0000;
         gs_busy_out   <= 1'b0;
         mem_req_out   <= 1'b0;
         mem_we_out    <= 1'b0;
         mem_addr_out  <= 64'h0000_0000_0000_0000;
         mem_wdata_out <= 64'h0000_0000_0000_0000;
      end else begin
         case (gs_st_r)
            vpr_pkg::VPR_GS_IDLE: begin
               if (gs_start_in) begin
                  gs_st_r     <= vpr_pkg::VPR_GS_SCAN;
                  gs_el_r     <= 6'h00;
                  gs_n_r      <= {vlq_r, 1'b0};
                  gs_store_r  <= gs_store_in;
                  gs_sv_r     <= gs_sv_in;
                  gs_vec_r    <= gs_vec_in;
                  gs_dat_r    <= gs_dat_in;
                  gs_gp_r     <= gs_gp_in;
                  gs_imm_r    <= gs_imm_in;
                  gs_scal_r   <= gs_scal_nxt;  // RULE14
                  gs_busy_out <= 1'b1;
               end
            end
            vpr_pkg::VPR_GS_SCAN: begin
               if (gs_el_r == gs_n_r) begin
                  gs_st_r     <= vpr_pkg::VPR_GS_IDLE;
                  gs_busy_out <= 1'b0;
               end else if (gs_act) begin
                  gs_st_r       <= vpr_pkg::VPR_GS_WAIT;
                  mem_req_out   <= 1'b1;
                  mem_we_out    <= gs_store_r;  // RULE16
                  mem_wdata_out <= gs_wdat;
                  mem_addr_out  <= gs_sv_r ? gs_scal_r + gs_elem
                                           : gs_elem + gs_imm_r;  // RULE15 RULE16
               end else begin
                  gs_el_r <= gs_el_r + 6'h01;
               end
            end
            vpr_pkg::VPR_GS_WAIT: begin
               if (mem_ack_in) begin
                  gs_st_r     <= vpr_pkg::VPR_GS_SCAN;
                  mem_req_out <= 1'b0;
                  mem_we_out  <= 1'b0;
                  gs_el_r     <= gs_el_r + 6'h01;
               end
            end
            default: begin
               gs_st_r     <= vpr_pkg::VPR_GS_IDLE;
               gs_busy_out <= 1'b0;
               mem_req_out <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   logic [4:0] chk_dst_r;
   logic [7:0] chk_old_r;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chk_dst_r <= 5'h00;
         chk_old_r <= 8'h00;
      end else begin
         chk_dst_r <= wr_tgt;
         chk_old_r <= vector_regs_r[wr_tgt][7:0];
      end
   end

   a_vl_limit: assert property (vlq_r >= 5'h01 && vlq_r <= 5'(MQ)  // RULE7
      && vlq_r <= 5'(vlen_ctrl_level3_in) + 5'h01 + 5'h00 || $past(cur_level_in) != cur_level_in
      || $changed(vlen_ctrl_level3_in)) else $error("vector length above limit");
   a_vl_level1: assert property (cur_level_in == 2'h1 && $stable(cur_level_in)  // RULE8
      && $stable(vlen_ctrl_level1_in) |=> vlq_r <= 5'(vlen_ctrl_level1_in) + 5'h01)
      else $error("level one length not applied");
   a_pred_len: assert property ((rd_p_out & ~$past(in_vl)) == '0)  // RULE9
      else $error("predicate bits past length");
   a_merge_keep: assert property (wr_valid_in && wr_pred_in && !wr_zero_in && !gp_bits[0]  // RULE2
      && !(gs_busy_out) |=> vector_regs_r[chk_dst_r][7:0] == chk_old_r)
      else $error("merge changed inactive element");
   a_zero_inact: assert property (wr_valid_in && wr_pred_in && wr_zero_in && !gp_bits[0]  // RULE3
      && !gs_busy_out |=> vector_regs_r[chk_dst_r][7:0] == 8'h00)
      else $error("zeroing left inactive element");
   a_destr_dst: assert property (wr_valid_in && !wr_pred_in && wr_destr_in  // RULE11
      && !gs_busy_out ##1 1'b1 |-> vector_regs_r[$past(wr_src_in)][7:0]
      == $past(wr_data_in[7:0])) else $error("destructive write misdirected");
   a_prefix_pair: assert property (op_valid_in && op_prefix_in ##1  // RULE13
      op_valid_in && !op_prefix_in |=> paired_out) else $error("prefixed op not paired");
   a_gs_hold: assert property (mem_req_out && !mem_ack_in |=>  // RULE15
      mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
      else $error("memory request dropped");
   a_gs_skip: assert property (gs_st_r == vpr_pkg::VPR_GS_SCAN && !gs_act  // RULE12
      |=> !mem_req_out) else $error("inactive element requested");
   a_scal_zero: assert property (gs_st_r == vpr_pkg::VPR_GS_IDLE && gs_start_in  // RULE14
      && scal_sel_in == vpr_pkg::SCAL_SEL_31 && !scal_base_in |=> gs_scal_r == '0)
      else $error("index 31 not zero");

   c_gather: cover property (mem_req_out && !mem_we_out && mem_ack_in);
   c_scatter: cover property (mem_req_out && mem_we_out && mem_ack_in);
   c_merge: cover property (wr_valid_in && wr_pred_in && !wr_zero_in);
   c_pair: cover property (paired_out);
endmodule

// ==== src/vpr_pkg.sv ====
// ****************************************
// vector and predicate file constants
// ****************************************
package vpr_pkg;
   // register counts and length limits
   localparam int NUM_VREG   = 32;
   localparam int NUM_PREG   = 16;
   localparam int VL_QUANT   = 128;
   localparam int VL_MIN     = 128;
   localparam int VL_MAX     = 2048;
   localparam int PL_QUANT   = 16;
   localparam int PL_MIN     = 16;
   localparam int PL_MAX     = 256;
   localparam int PRED_RATIO = 8;
   // length control field: vector length is (field + 1) * 128
   localparam int LEN_W      = 4;
   // gather and scatter move doublewords
   localparam int GS_EBITS   = 64;
   // scalar selector that means stack pointer or zero register
   localparam logic [4:0] SCAL_SEL_31 = 5'h1f;
   // values after reset
   localparam logic [1:0] LEVEL_RST   = 2'h0;

   // element sizes, code is log2 of bytes
   typedef enum logic [2:0] {
      VPR_ES_B = 3'b000,
      VPR_ES_H = 3'b001,
      VPR_ES_S = 3'b010,
      VPR_ES_D = 3'b011,
      VPR_ES_Q = 3'b100
   } vpr_esize_t;

   // gather and scatter sequencer
   typedef enum logic [1:0] {
      VPR_GS_IDLE = 2'b00,
      VPR_GS_SCAN = 2'b01,
      VPR_GS_WAIT = 2'b10
   } vpr_gs_state_t;
endpackage

// ==== test/vpr_mem_model.sv ====
`timescale 1ns/1ns
// ****************************************
// load/store side model
// ****************************************
module vpr_mem_model (
   // clock
   input  wire logic        clk_in,
   // request from the register file
   input  wire logic        req_in,
   input  wire logic        we_in,
   input  wire logic [63:0] addr_in,
   input  wire logic [63:0] wdata_in,
   // answer
   output logic             ack_out,
   output logic [63:0]      rdata_out
);
   int          wait_r = 0;
   logic [63:0] st_addr [$];
   logic [63:0] st_data [$];

   // load data scrambles the address so every element is distinct
   function automatic logic [63:0] mem_word(logic [63:0] a);
      return {a[31:0], ~a[63:32]};
   endfunction

   initial begin
      ack_out = 1'b0;
      rdata_out = 64'h0000_0000_0000_0000;
   end

   // one-cycle ack after 0 to 3 cycles; data toggles when not valid so a
   // late sample never matches by luck
   always @(negedge clk_in) begin
      if (!ack_out && req_in && wait_r == 0) begin
         ack_out <= 1'b1;
         rdata_out <= mem_word(addr_in);
         wait_r <= $urandom_range(3);
         if (we_in) begin
            st_addr.push_back(addr_in);
            st_data.push_back(wdata_in);
         end
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in && !ack_out) wait_r <= wait_r - 1;
      end
   end
endmodule

// ==== test/tb_vector_predicate_register_file.sv ====
`timescale 1ns/1ns
module tb_vector_predicate_register_file;
   // ****************************************
   // signals and shadow state
   // ****************************************
   localparam int VLM = 256; // two quads keep the run short
   localparam int PLM = VLM / 8;
   logic sys_clk_in, nrst_in, wr_valid_in, wr_destr_in, wr_pred_in, wr_zero_in, pw_valid_in;
   logic ff_we_in, op_valid_in, op_prefix_in, gs_start_in, gs_store_in, gs_sv_in;
   logic scal_base_in, mem_ack_in, paired_out, gs_busy_out, mem_req_out, mem_we_out;
   logic [1:0]                  cur_level_in;
   logic [vpr_pkg::LEN_W-1:0]   vlen_ctrl_level1_in, vlen_ctrl_level2_in, vlen_ctrl_level3_in;
   logic [3:0]                  rd_p_idx_in, wr_gp_idx_in, pw_idx_in, gs_gp_in;
   logic [4:0]                  rd_a_idx_in, rd_b_idx_in, wr_dst_in, wr_src_in, vl_quads_out;
   logic [4:0]                  gs_vec_in, gs_dat_in, scal_sel_in;
   logic [2:0]                  wr_esize_in;
   logic [VLM-1:0]              wr_data_in, rd_a_out, rd_b_out;
   logic [PLM-1:0]              pw_data_in, ff_data_in, rd_p_out, ff_out, ffs;
   logic [63:0]                 gs_imm_in, gpr_val_in, sp_val_in, mem_rdata_in;
   logic [63:0]                 mem_addr_out, mem_wdata_out;
   logic [VLM-1:0]              vs [32];
   logic [PLM-1:0]              ps [16];
   int                          fail_count = 0, n_tests = 0, vlq = 1;

   vpr_regfile #(.VLM(VLM)) i_vpr_regfile (.*);
   vpr_mem_model i_vpr_mem_model (.clk_in(sys_clk_in), .req_in(mem_req_out),
      .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // ****************************************
   // expectations and compares
   // ****************************************
   function automatic logic [VLM-1:0] vmask();
      return {VLM{1'b1}} >> (VLM - vlq * 128);
   endfunction
   function automatic logic [PLM-1:0] pmask();
      return {PLM{1'b1}} >> (PLM - vlq * 16);
   endfunction
   function automatic logic [VLM-1:0] rnd_v();
      logic [VLM-1:0] r;
      for (int i = 0; i < VLM / 32; i++) r[i*32 +: 32] = $urandom;
      return r;
   endfunction
   // byte lane b follows the low bit of the predicate element holding it
   function automatic logic [VLM-1:0] exp_wr(logic [VLM-1:0] o, logic [VLM-1:0] d, int es,
         logic pr, logic [PLM-1:0] p, logic z);
      logic [VLM-1:0] r;
      for (int b = 0; b < PLM; b++) begin
         if (!pr || p[b & ~((1 << es) - 1)]) r[b*8 +: 8] = d[b*8 +: 8];
         else r[b*8 +: 8] = z ? 8'h00 : o[b*8 +: 8];
      end
      return r & vmask();
   endfunction
   task automatic bad(string m);
      fail_count++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic chk_v(logic [VLM-1:0] got, logic [VLM-1:0] exp);
      n_tests++;
      if (got !== exp) bad("vector data mismatch");
   endtask
   task automatic chk_p(logic [PLM-1:0] got, logic [PLM-1:0] exp);
      n_tests++;
      if (got !== exp) bad("predicate data mismatch");
   endtask
   task automatic chk_n(logic [63:0] got, logic [63:0] exp);
      n_tests++;
      if (got !== exp) bad("value mismatch");
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // drivers, all changes at the falling edge
   // ****************************************
   task automatic wr_v(int dst, int src, logic de, int es, logic pr, int gp, logic z,
         logic [VLM-1:0] d);
      @(negedge sys_clk_in);
      {wr_dst_in, wr_src_in, wr_gp_idx_in, wr_esize_in} = {dst[4:0], src[4:0], gp[3:0], es[2:0]};
      {wr_destr_in, wr_pred_in, wr_zero_in, wr_valid_in} = {de, pr, z, 1'b1};
      wr_data_in = d;
      @(negedge sys_clk_in);
      wr_valid_in = 1'b0;
      if (de) dst = src;
      vs[dst] = exp_wr(vs[dst], d, es, pr, ps[gp], z);
   endtask
   task automatic wr_p(int i, logic [PLM-1:0] d);
      @(negedge sys_clk_in);
      {pw_idx_in, pw_data_in, ff_data_in, pw_valid_in, ff_we_in} = {i[3:0], d, ~d, 2'b11};
      @(negedge sys_clk_in);
      {pw_valid_in, ff_we_in} = 2'b00;
      ps[i] = d & pmask();
      ffs = ~d & pmask();
   endtask
   task automatic rd_chk(int i);
      @(negedge sys_clk_in);
      {rd_a_idx_in, rd_b_idx_in, rd_p_idx_in} = {i[4:0], 5'h1f - i[4:0], i[3:0]};
      @(negedge sys_clk_in);
      chk_v(rd_a_out, vs[i] & vmask());
      chk_v(rd_b_out, vs[31 - i] & vmask());
      chk_p(rd_p_out, ps[i % 16] & pmask());
      chk_p(ff_out, ffs & pmask());
   endtask
   task automatic set_len(int lev, int a, int b, int c);
      @(negedge sys_clk_in);
      {cur_level_in, vlen_ctrl_level1_in} = {lev[1:0], a[vpr_pkg::LEN_W-1:0]};
      vlen_ctrl_level2_in = b[vpr_pkg::LEN_W-1:0];
      vlen_ctrl_level3_in = c[vpr_pkg::LEN_W-1:0];
      vlq = ((lev == 3) ? c : (b < c ? b : c));
      if (lev < 2 && a < vlq) vlq = a;
      vlq++;
      @(negedge sys_clk_in);
      chk_n(vl_quads_out, vlq);
   endtask
   // an op after a prefix, with gap idle cycles between, pulses paired once
   task automatic op_seq(logic pf, int gap, logic [63:0] exp);
      logic [63:0] n;
      n = '0;
      if (pf) begin
         @(negedge sys_clk_in);
         {op_valid_in, op_prefix_in} = 2'b11;
      end
      repeat (gap) @(negedge sys_clk_in) op_valid_in = 1'b0;
      @(negedge sys_clk_in);
      {op_valid_in, op_prefix_in} = 2'b10;
      repeat (3) begin
         @(negedge sys_clk_in);
         op_valid_in = 1'b0;
         n = n + paired_out;
      end
      chk_n(n, exp);
   endtask
   task automatic gs_run(logic st, logic sv, int vec, int dat, int gp, int sel, logic bs);
      logic [63:0] off, a;
      int k;
      @(negedge sys_clk_in);
      {gs_store_in, gs_sv_in, scal_base_in, gs_start_in} = {st, sv, bs, 1'b1};
      {gs_vec_in, gs_dat_in, gs_gp_in, scal_sel_in} = {vec[4:0], dat[4:0], gp[3:0], sel[4:0]};
      {gpr_val_in, sp_val_in, gs_imm_in} = {$urandom, $urandom, $urandom, $urandom,
         $urandom, $urandom};
      off = !sv ? gs_imm_in : sel != 31 ? gpr_val_in : bs ? sp_val_in : '0;
      @(negedge sys_clk_in);
      gs_start_in = 1'b0;
      for (k = 0; k < 300 && gs_busy_out !== 1'b0; k++) @(negedge sys_clk_in);
      if (k == 300) begin
         bad("gather or scatter hung");
         wrap_up();
      end
      for (int e = 0; e < 2 * vlq; e++) begin
         a = vs[vec][e*64 +: 64] + off;
         if (st && ps[gp][e*8]) begin
            chk_n(i_vpr_mem_model.st_addr.pop_front(), a);
            chk_n(i_vpr_mem_model.st_data.pop_front(), vs[dat][e*64 +: 64]);
         end
         if (!st) vs[dat][e*64 +: 64] = ps[gp][e*8] ? i_vpr_mem_model.mem_word(a) : '0;
      end
      chk_n(i_vpr_mem_model.st_addr.size(), 0);
      rd_chk(dat);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int dst, src;
      logic de;
      void'($urandom(38351));
      {cur_level_in, vlen_ctrl_level1_in, vlen_ctrl_level2_in, vlen_ctrl_level3_in,
         rd_a_idx_in, rd_b_idx_in, rd_p_idx_in, wr_valid_in, wr_destr_in, wr_dst_in,
         wr_src_in, wr_esize_in, wr_pred_in, wr_gp_idx_in, wr_zero_in, wr_data_in,
         pw_valid_in, pw_idx_in, pw_data_in, ff_we_in, ff_data_in, op_valid_in, op_prefix_in,
         gs_start_in, gs_store_in, gs_sv_in, gs_vec_in, gs_dat_in, gs_gp_in, gs_imm_in,
         scal_sel_in, scal_base_in, gpr_val_in, sp_val_in, nrst_in, ffs} = '0;
      foreach (vs[i]) vs[i] = '0;
      foreach (ps[i]) ps[i] = '0;
      repeat (8) @(negedge sys_clk_in);
      nrst_in = 1'b1;
      chk_n(vl_quads_out, 1);
      wr_v(0, 0, 0, 0, 0, 0, 0, rnd_v());
      rd_chk(0);
      repeat (20) set_len($urandom_range(3), $urandom_range(1), $urandom_range(1),
         $urandom_range(1));
      set_len(3, 1, 1, 1);
      rd_chk(0);
      for (int i = 0; i < 32; i++) wr_v(i, 0, 0, i % 5, 0, 0, 0, rnd_v());
      for (int i = 0; i < 16; i++) wr_p(i, i == 14 ? '0 : i == 15 ? '1 : $urandom);
      for (int i = 0; i < 32; i++) rd_chk(i);
      for (int g = 0; g < 4; g++) op_seq(1'b1, g, 1);
      op_seq(1'b0, 0, 0);
      for (int pass = 0; pass < 2; pass++) begin
         if (pass == 1) set_len(1, 0, 1, 1);
         for (int i = 0; i < 40; i++) begin
            dst = $urandom_range(31);
            src = $urandom_range(31);
            de = $urandom_range(1);
            wr_v(dst, src, de, i % 5, i % 4 != 3, $urandom_range(15), $urandom_range(1),
               rnd_v());
            rd_chk(de ? src : dst);
         end
         for (int i = 0; i < 16; i++) begin
            src = $urandom_range(31);
            gs_run(i % 2, (i / 2) % 2, src, (src + 1 + $urandom_range(29)) % 32,
               $urandom_range(15), i < 8 ? 31 : $urandom_range(31), (i / 4) % 2);
         end
      end
      wrap_up();
   end
endmodule
